// ==== logic/cfx_exc_unit.sv ====
// exception detection, frame push and vector fetch of the core
`default_nettype none
// What this block does
// - frame is two longwords: format/vector over state word, then program counter.
// - format is 4 plus old stack pointer bits 1:0; pointer drops 8 to 11.
// - fault status only for access and address errors, else zeros.
// - fault status codes: fetch 0100, write 1000, protected 1001, read 1100.
// - vector is internal for faults, interrupt controller value for interrupts.
// - prefetch errors wait until used; flushed prefetches raise nothing.
// - executing a faulted word aborts with access error and no state change.
// - operand read error aborts at once; earlier register updates stay.
// - operand write errors are imprecise; program counter is where signalled.
// - no-operation instruction stalls for pending writes and reports their errors.
// - control transfer to an odd address raises an address error.
// - word index, scale eight or full-format extension raises an address error.
// - call faults after pushing return; return frame overwrites stacked address.
// - instructions are 16, 32 or 48 bits; opword is line, opmode, ea.
// - illegal operation word outside lines A and F raises vector 4.
// - unimplemented line A raises vector 10, line F raises vector 11.
// - extension words are never checked for legality.
// - line A legal for multiply-accumulate and quick move; line F for debug ops.
// - handler address is read from vector base plus four times vector.
// - exception entry saves state word, sets supervisor, clears trace.
module cfx_exc_unit #(
  parameter int PF_DEPTH    = 4,
  parameter bit MAC_PRESENT = 1'b1
) (
  input  wire logic        clk_i,          // core clock
  input  wire logic        rst_i,          // synchronous reset
  input  wire logic [7:0]  wb_adr_i,       // register byte address
  input  wire logic [31:0] wb_dat_i,       // register write data
  output logic      [31:0] wb_dat_o,       // register read data
  input  wire logic [3:0]  wb_sel_i,       // byte enables
  input  wire logic        wb_we_i,        // write strobe
  input  wire logic        wb_cyc_i,       // bus cycle
  input  wire logic        wb_stb_i,       // bus strobe
  output logic             wb_ack_o,       // bus acknowledge
  output logic      [31:0] m_adr_o,        // memory address
  output logic      [31:0] m_dat_o,        // memory write data
  input  wire logic [31:0] m_dat_i,        // memory read data
  output logic      [3:0]  m_sel_o,        // memory byte enables
  output logic             m_we_o,         // memory write
  output logic             m_cyc_o,        // memory cycle
  output logic             m_stb_o,        // memory strobe
  input  wire logic        m_ack_i,        // memory acknowledge
  input  wire logic        m_err_i,        // memory error during the frame
  input  wire logic        fetch_word_i,   // a prefetch word arrives
  input  wire logic        fetch_err_i,    // that word was fetched with an error
  input  wire logic        flush_i,        // prefetch queue discarded
  input  wire logic        exec_i,         // instruction at its boundary
  input  wire logic [15:0] opword_i,       // its operation word
  input  wire logic [15:0] ext1_i,         // its extension word 1
  input  wire logic [1:0]  ext_cnt_i,      // number of extension words
  input  wire logic        known_i,        // decoder recognised the opword
  input  wire logic        mac_op_i,       // opword is a multiply-accumulate op
  input  wire logic        indexed_i,      // indexed addressing mode in use
  input  wire logic        idx_word_i,     // word_index_register selected
  input  wire logic [1:0]  idx_scale_i,    // index scale code
  input  wire logic        nop_i,          // no_operation_instruction
  input  wire logic        rd_err_i,       // operand read error
  input  wire logic        wr_err_i,       // buffered operand write error
  input  wire logic        wr_prot_i,      // that write hit protected space
  input  wire logic        wr_pending_i,   // buffered writes outstanding
  input  wire logic [31:0] target_i,       // control transfer target
  input  wire logic        target_vld_i,   // target valid
  input  wire logic        call_i,         // transfer is a subroutine_call
  input  wire logic        call_pushed_i,  // return address push finished
  input  wire logic        irq_i,          // interrupt pending
  input  wire logic [7:0]  irq_vec_i,      // vector from the interrupt controller
  input  wire logic [31:0] pc_i,           // program counter of the instruction
  input  wire logic [15:0] sr_i,           // processor_state_word
  output logic             abort_o,        // abort the current instruction
  output logic             discard_o,      // abort without any state change
  output logic             stall_o,        // hold the instruction at its boundary
  output logic             exc_busy_o,     // exception processing underway
  output logic      [15:0] sr_new_o,       // state word for the handler
  output logic      [31:0] handler_pc_o,   // first handler address
  output logic             handler_go_o,   // start fetch at handler_pc_o
  output logic      [5:0]  inst_bits_o,    // length of the last instruction
  output logic             halt_o          // fault during exception processing
);
  localparam int CW = $clog2(PF_DEPTH + 1);

  cfx_pkg::cfx_state_t state_q;
  cfx_pkg::cfx_state_t nxt_state;
  logic [31:0]         vbr_q;
  logic [31:0]         ssp_q;
  logic [31:0]         fpc_q;
  logic [31:0]         fv_q;
  logic [31:0]         base_q;
  logic [31:0]         pcadr_q;
  logic [7:0]          vec_q;
  logic [3:0]          fs_q;
  logic                wr_err_q;
  logic [3:0]          wr_fs_q;
  logic                odd_pend_q;
  logic                odd_call_q;
  logic [PF_DEPTH-1:0] pf_q;
  logic [PF_DEPTH-1:0] pf_d;
  logic [PF_DEPTH-1:0] pf_shift;
  logic [CW-1:0]       pf_cnt_q;
  logic [CW-1:0]       pf_base;
  logic [CW-1:0]       take_n;
  logic                idle;
  logic                nop_hold;
  logic                exec_ok;
  logic                pf_hit;
  logic                idx_bad;
  logic                odd_fire;
  logic                raise;
  logic                r_disc;
  logic                r_wr;
  logic                r_odd;
  logic [7:0]          r_vec;
  logic [3:0]          r_fs;
  logic [31:0]         req_adr;
  logic [31:0]         req_dat;
  logic                req_we;
  logic [3:0]          chk_line;
  logic [5:0]          chk_bits;
  logic                chk_illegal;
  logic [7:0]          chk_vec;
  logic [31:0]         fr_word;
  logic [31:0]         fr_base;
  logic [31:0]         fr_pcadr;
  logic                wb_hit;
  logic [31:0]         wmask;

  cfx_opword_chk #(.MAC_PRESENT(MAC_PRESENT)) u_chk (
    .opword_i  (opword_i),
    .known_i   (known_i),
    .mac_op_i  (mac_op_i),
    .ext_cnt_i (ext_cnt_i),
    .line_o    (chk_line),
    .opmode_o  (),
    .ea_o      (),
    .bits_o    (chk_bits),
    .illegal_o (chk_illegal),
    .vec_o     (chk_vec)
  );

  cfx_frame_fmt u_frame (
    .sp_i    (ssp_q),
    .sr_i    (sr_i),
    .vec_i   (r_vec),
    .fs_i    (r_fs),
    .word_o  (fr_word),
    .base_o  (fr_base),
    .pcadr_o (fr_pcadr)
  );

  assign idle     = (state_q == cfx_pkg::CFX_IDLE);
  assign nop_hold = nop_i & wr_pending_i;
  assign exec_ok  = exec_i & ~nop_hold & idle;

  // prefetch error flags travel with their words; a flush drops them unseen
  assign take_n   = exec_ok ? CW'(ext_cnt_i) + CW'(1) : '0;
  assign pf_shift = flush_i ? '0 : pf_q >> take_n;
  assign pf_base  = (flush_i || pf_cnt_q < take_n) ? '0 : pf_cnt_q - take_n;
  assign pf_hit   = |(pf_q & ~({PF_DEPTH{1'b1}} << take_n));

  for (genvar i = 0; i < PF_DEPTH; i++)
  begin : g_pf
    assign pf_d[i] = pf_shift[i] | (fetch_word_i & fetch_err_i & (pf_base == CW'(i)));
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pf_q     <= '0;
      pf_cnt_q <= '0;
    end
    else
    begin
      pf_q     <= pf_d;
      pf_cnt_q <= pf_base + CW'(fetch_word_i & (pf_base != CW'(PF_DEPTH)));
    end
  end

  assign idx_bad  = indexed_i & (idx_word_i | (idx_scale_i == cfx_pkg::IDX_SCALE8)
                    | ext1_i[cfx_pkg::IDX_FULL_BIT]);
  // a call may fault only once its return address is on the stack
  assign odd_fire = odd_pend_q & (~odd_call_q | call_pushed_i);

  // priority: read error, odd target, then causes found at the boundary
  always_comb
  begin
    raise  = 1'b0;
    r_disc = 1'b0;
    r_wr   = 1'b0;
    r_odd  = 1'b0;
    r_vec  = cfx_pkg::VEC_ACCESS;
    r_fs   = cfx_pkg::FS_NONE;
    if (rd_err_i)
    begin
      raise = 1'b1;
      r_fs  = cfx_pkg::FS_OPRD;
    end
    else if (odd_fire)
    begin
      raise = 1'b1;
      r_odd = 1'b1;
      r_vec = cfx_pkg::VEC_ADDR;
      r_fs  = cfx_pkg::FS_IFETCH;
    end
    else if (exec_ok)
    begin
      r_disc = 1'b1;
      raise  = 1'b1;
      if (wr_err_q)
      begin
        r_wr = 1'b1;
        r_fs = wr_fs_q;
      end
      else if (pf_hit)
        r_fs = cfx_pkg::FS_IFETCH;
      else if (chk_illegal)
        r_vec = chk_vec;
      else if (idx_bad)
      begin
        r_vec = cfx_pkg::VEC_ADDR;
        r_fs  = cfx_pkg::FS_OPRD;
      end
      else if (irq_i)
      begin
        r_disc = 1'b0;
        r_vec  = irq_vec_i;
      end
      else
      begin
        raise  = 1'b0;
        r_disc = 1'b0;
      end
    end
  end

  // a write error arriving as the old one is reported stays pending
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wr_err_q <= 1'b0;
      wr_fs_q  <= cfx_pkg::FS_NONE;
    end
    else if (wr_err_i)
    begin
      wr_err_q <= 1'b1;
      wr_fs_q  <= wr_prot_i ? cfx_pkg::FS_WPROT : cfx_pkg::FS_OPWR;
    end
    else if (idle & raise & r_wr)
      wr_err_q <= 1'b0;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      odd_pend_q <= 1'b0;
      odd_call_q <= 1'b0;
    end
    else if (target_vld_i & target_i[0])
    begin
      odd_pend_q <= 1'b1;
      odd_call_q <= call_i;
    end
    else if (idle & raise & r_odd)
      odd_pend_q <= 1'b0;
  end

  // pc longword first so both frame words land before the vector read
  always_comb
  begin
    req_adr   = pcadr_q;
    req_dat   = fpc_q;
    req_we    = 1'b1;
    nxt_state = state_q;
    unique case (state_q)
      cfx_pkg::CFX_WR_PC: nxt_state = cfx_pkg::CFX_WR_FV;
      cfx_pkg::CFX_WR_FV:
      begin
        req_adr   = base_q;
        req_dat   = fv_q;
        nxt_state = cfx_pkg::CFX_RD_VEC;
      end
      cfx_pkg::CFX_RD_VEC:
      begin
        req_adr   = vbr_q + {22'h0, vec_q, 2'h0};
        req_we    = 1'b0;
        nxt_state = cfx_pkg::CFX_IDLE;
      end
      cfx_pkg::CFX_IDLE: nxt_state = cfx_pkg::CFX_IDLE;
      cfx_pkg::CFX_HALT: nxt_state = cfx_pkg::CFX_HALT;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_q      <= cfx_pkg::CFX_IDLE;
      m_cyc_o      <= 1'b0;
      m_stb_o      <= 1'b0;
      m_we_o       <= 1'b0;
      m_sel_o      <= 4'h0;
      m_adr_o      <= 32'h0000_0000;
      m_dat_o      <= 32'h0000_0000;
      handler_pc_o <= 32'h0000_0000;
      vec_q        <= 8'h00;
      fs_q         <= cfx_pkg::FS_NONE;
      fv_q         <= 32'h0000_0000;
      base_q       <= 32'h0000_0000;
      pcadr_q      <= 32'h0000_0000;
      fpc_q        <= 32'h0000_0000;
    end
    else if (idle)
    begin
      if (raise)
      begin
        state_q <= cfx_pkg::CFX_WR_PC;
        vec_q   <= r_vec;
        fs_q    <= r_fs;
        fv_q    <= fr_word;
        base_q  <= fr_base;
        pcadr_q <= fr_pcadr;
        fpc_q   <= pc_i;
      end
    end
    else if (m_cyc_o & m_err_i)
    begin
      state_q <= cfx_pkg::CFX_HALT;
      m_cyc_o <= 1'b0;
      m_stb_o <= 1'b0;
    end
    else if (m_cyc_o & m_ack_i)
    begin
      state_q <= nxt_state;
      m_cyc_o <= 1'b0;
      m_stb_o <= 1'b0;
      if (state_q == cfx_pkg::CFX_RD_VEC)
        handler_pc_o <= m_dat_i;
    end
    else if (~m_cyc_o & (state_q != cfx_pkg::CFX_HALT))
    begin
      m_cyc_o <= 1'b1;
      m_stb_o <= 1'b1;
      m_we_o  <= req_we;
      m_sel_o <= cfx_pkg::SEL_ALL;
      m_adr_o <= req_adr;
      m_dat_o <= req_dat;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      abort_o      <= 1'b0;
      discard_o    <= 1'b0;
      stall_o      <= 1'b0;
      exc_busy_o   <= 1'b0;
      handler_go_o <= 1'b0;
      halt_o       <= 1'b0;
      sr_new_o     <= 16'h0000;
      inst_bits_o  <= 6'h00;
    end
    else
    begin
      abort_o      <= idle & raise;
      discard_o    <= idle & raise & r_disc;
      stall_o      <= exec_i & nop_hold;
      handler_go_o <= (state_q == cfx_pkg::CFX_RD_VEC) & m_cyc_o & m_ack_i & ~m_err_i;
      halt_o       <= (state_q == cfx_pkg::CFX_HALT);
      exc_busy_o   <= idle ? raise : (nxt_state != cfx_pkg::CFX_IDLE) | ~m_ack_i;
      if (exec_ok)
        inst_bits_o <= chk_bits;
      if (idle & raise)
      begin
        sr_new_o                    <= sr_i;
        sr_new_o[cfx_pkg::SR_S_BIT] <= 1'b1;
        sr_new_o[cfx_pkg::SR_T_BIT] <= 1'b0;
      end
    end
  end

  // register slave: answers every address one cycle after the strobe
  assign wb_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  for (genvar b = 0; b < 4; b++)
  begin : g_wmask
    assign wmask[8*b +: 8] = {8{wb_sel_i[b]}};
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      vbr_q    <= cfx_pkg::VBR_RST;
      ssp_q    <= cfx_pkg::SSP_RST;
    end
    else
    begin
      wb_ack_o <= wb_hit;
      if (wb_hit & wb_we_i & (wb_adr_i == cfx_pkg::RA_VBR))
        vbr_q <= (vbr_q & ~wmask) | (wb_dat_i & wmask);
      // the hardware pointer update wins over a software write
      if (handler_go_o)
        ssp_q <= base_q;
      else if (wb_hit & wb_we_i & (wb_adr_i == cfx_pkg::RA_SSP))
        ssp_q <= (ssp_q & ~wmask) | (wb_dat_i & wmask);
      unique case (wb_adr_i)
        cfx_pkg::RA_VBR:  wb_dat_o <= vbr_q;
        cfx_pkg::RA_SSP:  wb_dat_o <= ssp_q;
        cfx_pkg::RA_STAT: wb_dat_o <= {8'h00, vec_q, 4'h0, fs_q, fv_q[31:28], 2'h0,
                                       halt_o, exc_busy_o};
        cfx_pkg::RA_FPC:  wb_dat_o <= fpc_q;
        default:          wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_rd_err_keep:   assert property (idle && rd_err_i |=> abort_o && !discard_o
                     && fs_q == cfx_pkg::FS_OPRD)
    else $error("read error not taken as a keep-state abort");
  a_fmt_field:     assert property (state_q == cfx_pkg::CFX_WR_FV && m_cyc_o
                     |-> m_dat_o[31:28] == {cfx_pkg::FMT_HI, ssp_q[1:0]})
    else $error("frame format does not follow stack pointer");
  a_frame_base:    assert property (state_q == cfx_pkg::CFX_WR_FV && m_cyc_o
                     |-> m_adr_o == {ssp_q[31:2], 2'h0} - 32'h0000_0008)
    else $error("frame base address wrong");
  a_pc_first:      assert property (idle ##1 !idle |-> state_q == cfx_pkg::CFX_WR_PC
                     || state_q == cfx_pkg::CFX_HALT)
    else $error("frame not started with pc longword");
  a_vec_addr:      assert property (state_q == cfx_pkg::CFX_RD_VEC && m_cyc_o
                     |-> m_adr_o == vbr_q + 4 * vec_q && !m_we_o)
    else $error("vector fetch address wrong");
  a_sr_super:      assert property (abort_o |-> sr_new_o[13] && !sr_new_o[15])
    else $error("handler state word not supervisor");
  a_fs_zero:       assert property (state_q == cfx_pkg::CFX_WR_FV && m_cyc_o && vec_q > 8'h03
                     |-> {m_dat_o[27:26], m_dat_o[17:16]} == 4'h0)
    else $error("fault status set for a non-access exception");
  a_pf_abort:      assert property (exec_ok && !rd_err_i && !odd_fire && !wr_err_q
                     && pf_hit |=> discard_o && fs_q == 4'h4)
    else $error("faulted prefetch word not aborted");
  a_line_a:        assert property (chk_illegal && chk_line == 4'hA
                     |-> chk_vec == 8'h0A)
    else $error("line A illegal word has wrong vector");
  a_illegal_vec:   assert property (exec_ok && !rd_err_i && !odd_fire && !wr_err_q
                     && !pf_hit && chk_illegal |=> vec_q == $past(chk_vec))
    else $error("illegal word vector not latched");
  a_nop_stall:     assert property (exec_i && nop_i && wr_pending_i && !rd_err_i && !odd_fire
                     |=> stall_o && !abort_o)
    else $error("no-operation instruction did not stall");
  a_call_wait:     assert property (odd_pend_q && odd_call_q && !call_pushed_i
                     && !rd_err_i |=> !(abort_o && vec_q == 8'h03))
    else $error("call faulted before its push");

  c_rd_err:  cover property (idle && rd_err_i ##[1:20] handler_go_o);
  c_illegal: cover property (exec_ok && chk_illegal ##[1:20] handler_go_o);
  c_nop:     cover property (stall_o [*3] ##1 !stall_o);
  c_halt:    cover property (!halt_o ##1 halt_o);
endmodule
`default_nettype wire

// ==== common/cfx_pkg.sv ====
// shared constants and types for the exception frame unit
`default_nettype none
package cfx_pkg;
  // fault status codes
  localparam logic [3:0]  FS_NONE      = 4'h0;
  localparam logic [3:0]  FS_IFETCH    = 4'h4;
  localparam logic [3:0]  FS_OPWR      = 4'h8;
  localparam logic [3:0]  FS_WPROT     = 4'h9;
  localparam logic [3:0]  FS_OPRD      = 4'hC;
  // exception vector numbers
  localparam logic [7:0]  VEC_ACCESS   = 8'h02;
  localparam logic [7:0]  VEC_ADDR     = 8'h03;
  localparam logic [7:0]  VEC_ILLEGAL  = 8'h04;
  localparam logic [7:0]  VEC_LINE_A   = 8'h0A;
  localparam logic [7:0]  VEC_LINE_F   = 8'h0B;
  // frame layout
  localparam logic [1:0]  FMT_HI       = 2'h1;
  localparam logic [31:0] FRAME_BYTES  = 32'h0000_0008;
  localparam logic [31:0] PC_OFS       = 32'h0000_0004;
  localparam int          SR_T_BIT     = 15;
  localparam int          SR_S_BIT     = 13;
  // opword decode
  localparam logic [3:0]  LINE_A       = 4'hA;
  localparam logic [3:0]  LINE_F       = 4'hF;
  localparam logic [5:0]  WORD_BITS    = 6'h10;
  localparam int          IDX_FULL_BIT = 8;
  localparam logic [1:0]  IDX_SCALE8   = 2'h3;
  // register offsets and reset values
  localparam logic [7:0]  RA_VBR       = 8'h00;
  localparam logic [7:0]  RA_SSP       = 8'h04;
  localparam logic [7:0]  RA_STAT      = 8'h08;
  localparam logic [7:0]  RA_FPC       = 8'h0C;
  localparam logic [31:0] VBR_RST      = 32'h0000_0000;
  localparam logic [31:0] SSP_RST      = 32'h0000_0000;
  localparam logic [3:0]  SEL_ALL      = 4'hF;

  typedef enum logic [4:0] {
    CFX_IDLE   = 5'h01,
    CFX_WR_PC  = 5'h02,
    CFX_WR_FV  = 5'h04,
    CFX_RD_VEC = 5'h08,
    CFX_HALT   = 5'h10
  } cfx_state_t;
endpackage
`default_nettype wire

// ==== logic/cfx_frame_fmt.sv ====
// exception frame word and address formatter
`default_nettype none
module cfx_frame_fmt (
  input  wire logic [31:0] sp_i,    // supervisor stack pointer before the frame
  input  wire logic [15:0] sr_i,    // saved processor state word
  input  wire logic [7:0]  vec_i,   // vector number
  input  wire logic [3:0]  fs_i,    // fault status
  output logic      [31:0] word_o,  // format, vector and state longword
  output logic      [31:0] base_o,  // frame base, also the new stack pointer
  output logic      [31:0] pcadr_o  // address of the program counter longword
);
  logic [3:0] fmt;

  // misalignment of the old pointer is folded into the format
  assign fmt     = {cfx_pkg::FMT_HI, sp_i[1:0]};
  assign word_o  = {fmt, fs_i[3:2], vec_i, fs_i[1:0], sr_i};
  // the frame sits on a longword boundary, so 8 to 11 bytes are dropped
  assign base_o  = {sp_i[31:2], 2'h0} - cfx_pkg::FRAME_BYTES;
  assign pcadr_o = base_o + cfx_pkg::PC_OFS;
endmodule
`default_nettype wire

// ==== logic/cfx_opword_chk.sv ====
// first-word legality check and field split
`default_nettype none
module cfx_opword_chk #(
  parameter bit MAC_PRESENT = 1'b1
) (
  input  wire logic [15:0] opword_i,  // operation word
  input  wire logic        known_i,   // decoder recognised the operation word
  input  wire logic        mac_op_i,  // operation word is a multiply_accumulate_unit op
  input  wire logic [1:0]  ext_cnt_i, // number of extension words
  output logic      [3:0]  line_o,    // line field
  output logic      [5:0]  opmode_o,  // operation-mode field
  output logic      [5:0]  ea_o,      // effective-address field
  output logic      [5:0]  bits_o,    // instruction length in bits
  output logic             illegal_o, // operation word may not execute
  output logic      [7:0]  vec_o      // vector to raise when illegal
);
  logic legal;

  assign line_o   = opword_i[15:12];
  assign opmode_o = opword_i[11:6];
  assign ea_o     = opword_i[5:0];
  assign bits_o   = cfx_pkg::WORD_BITS * (6'h01 + {4'h0, ext_cnt_i});

  // only the first word is judged; extension words never are
  always_comb
  begin
    legal = known_i;
    if (line_o == cfx_pkg::LINE_A)
      legal = mac_op_i ? MAC_PRESENT : known_i;
    illegal_o = ~legal;
    unique case (line_o)
      cfx_pkg::LINE_A: vec_o = cfx_pkg::VEC_LINE_A;
      cfx_pkg::LINE_F: vec_o = cfx_pkg::VEC_LINE_F;
      default:         vec_o = cfx_pkg::VEC_ILLEGAL;
    endcase
  end
endmodule
`default_nettype wire

// ==== sim/cfx_mem_model.sv ====
// system memory model behind the exception unit's master port
`default_nettype none
module cfx_mem_model (
  input  wire logic        clk_i,  // core clock
  input  wire logic        rst_i,  // synchronous reset
  input  wire logic [31:0] adr_i,  // byte address
  input  wire logic        cyc_i,  // bus cycle
  input  wire logic        stb_i,  // bus strobe
  output logic             ack_o,  // one-cycle acknowledge
  output logic      [31:0] dat_o   // read data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] wait_q;
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !(cyc_i && stb_i) || ack_o)
    begin
      ack_o  <= 1'b0;
      wait_q <= 2'($urandom);
      // released data keeps toggling so a stale read cannot match
      dat_o  <= rst_i ? 32'h0 : ~dat_o;
    end
    else if (wait_q == 2'h0)
    begin
      ack_o <= 1'b1;
      dat_o <= ~adr_i;
    end
    else
      wait_q <= wait_q - 2'h1;
  end
endmodule
`default_nettype wire

// ==== sim/cfx_exc_unit_tb_top.sv ====
// self-checking bench for the exception frame unit
`default_nettype none
module cfx_exc_unit_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 0, rst_i = 1, wb_we_i = 0, wb_cyc_i = 0, wb_stb_i = 0, m_err_i = 0;
  logic fetch_word_i = 0, fetch_err_i = 0, flush_i = 0, exec_i = 0, known_i = 0;
  logic mac_op_i = 0, indexed_i = 0, idx_word_i = 0, nop_i = 0, rd_err_i = 0;
  logic wr_err_i = 0, wr_prot_i = 0, wr_pending_i = 0, target_vld_i = 0, call_i = 0;
  logic call_pushed_i = 0, irq_i = 0, m_ack_i, wb_ack_o, m_we_o, m_cyc_o, m_stb_o;
  logic handler_go_o, abort_o, discard_o, stall_o, exc_busy_o, halt_o;
  logic [15:0] sr_new_o, sr;
  logic [1:0] ext_cnt_i = 0, idx_scale_i = 0;
  logic [3:0] wb_sel_i = 4'hF;
  logic [7:0] wb_adr_i = 0, irq_vec_i = 8'h47;
  logic [15:0] opword_i = 0, ext1_i = 0, sr_i = 16'h2704;
  logic [31:0] wb_dat_i = 0, target_i = 0, pc_i = 0, m_dat_i, wb_dat_o, m_adr_o, m_dat_o;
  logic [31:0] handler_pc_o, vbr, supervisor_stack_pointer, base, hv, pc;
  localparam logic [6:0] DSC = 7'h5C;
  logic [63:0] exp_q[$];
  int errors = 0, tests_run = 0, cyc_n = 0;
  localparam logic [15:0] OP[7] = '{0, 0, 16'h4AFC, 16'hA1C0, 16'hFFFF, 16'h4E71, 16'h2030};
  localparam logic [5:0] CTL[7] = '{0, 0, 0, 0, 0, 6'h21, 6'h2E};
  localparam logic [7:0] VEC[7] = '{cfx_pkg::VEC_ACCESS, cfx_pkg::VEC_ADDR,
    cfx_pkg::VEC_ILLEGAL, cfx_pkg::VEC_LINE_A, cfx_pkg::VEC_LINE_F, 8'h47, cfx_pkg::VEC_ADDR};
  localparam logic [3:0] FS[7] = '{cfx_pkg::FS_OPRD, cfx_pkg::FS_IFETCH, 0, 0, 0, 0,
    cfx_pkg::FS_OPRD};
  cfx_exc_unit i_cfx_exc_unit (.clk_i, .rst_i, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_sel_i,
    .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .m_adr_o, .m_dat_o, .m_dat_i, .m_sel_o(),
    .m_we_o, .m_cyc_o, .m_stb_o, .m_ack_i, .m_err_i, .fetch_word_i, .fetch_err_i, .flush_i,
    .exec_i, .opword_i, .ext1_i, .ext_cnt_i, .known_i, .mac_op_i, .indexed_i, .idx_word_i,
    .idx_scale_i, .nop_i, .rd_err_i, .wr_err_i, .wr_prot_i, .wr_pending_i, .target_i,
    .target_vld_i, .call_i, .call_pushed_i, .irq_i, .irq_vec_i, .pc_i, .sr_i, .abort_o,
    .discard_o, .stall_o, .exc_busy_o, .sr_new_o, .handler_pc_o, .handler_go_o,
    .inst_bits_o(), .halt_o);
  cfx_mem_model i_cfx_mem_model (.clk_i, .rst_i, .adr_i(m_adr_o), .cyc_i(m_cyc_o),
    .stb_i(m_stb_o), .ack_o(m_ack_i), .dat_o(m_dat_i));
  initial
  begin
    forever #10 clk_i = ~clk_i;
  end
  task automatic final_report();
    if (errors == 0 && tests_run > 0 && exp_q.size() == 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic cmp(input string what, input logic [63:0] got);
    logic [63:0] e;
    e = exp_q.size() > 0 ? exp_q.pop_front() : 'x;
    tests_run++;
    if (got !== e)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, got);
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, a, d};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask
  // one ordered queue: aborts, frame cycles, handler start and register reads
  always @(posedge clk_i)
  begin
    cyc_n++;
    if (cyc_n > 3000)
    begin
      errors++;
      final_report();
    end
    if (m_cyc_o && m_stb_o && m_ack_i)
      cmp("frame cycle", {m_adr_o, m_we_o ? m_dat_o : m_dat_i});
    if (abort_o)
      cmp("abort", {44'h0, exc_busy_o, halt_o, stall_o, discard_o, sr_new_o});
    if (handler_go_o)
      cmp("handler", {31'h0, exc_busy_o, handler_pc_o});
    if (wb_ack_o && !wb_we_i)
      cmp("register read", {32'h0, wb_dat_o});
  end
  initial
  begin
    void'($urandom(32'h60E8F1ED));
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 7; i++)
    begin
      vbr = {12'($urandom), 20'h0};
      supervisor_stack_pointer = {16'h0001, 14'($urandom), i[1:0]};
      base = {supervisor_stack_pointer[31:2], 2'b00} - 32'h8;
      hv = vbr + {22'h0, VEC[i], 2'b00};
      wb(1'b1, 8'h00, vbr);
      wb(1'b1, 8'h04, supervisor_stack_pointer);
      exp_q.push_back({32'h0, vbr});
      wb(1'b0, 8'h00, 32'h0);
      @(posedge clk_i);
      pc = {16'h0002, 15'($urandom), 1'b0};
      sr = 16'($urandom) | 16'h8000;
      {pc_i, sr_i} <= {pc, sr};
      exp_q.push_back({44'h0, 3'b100, DSC[i], 1'b0, sr[14], 1'b1, sr[12:0]});
      exp_q.push_back({base + 32'h4, pc});
      exp_q.push_back({base, 2'b01, supervisor_stack_pointer[1:0], FS[i][3:2], VEC[i], FS[i][1:0], sr});
      exp_q.push_back({hv, ~hv});
      exp_q.push_back({32'h0, ~hv});
      exp_q.push_back({32'h0, base});
      @(posedge clk_i);
      case (i)
        0: rd_err_i <= 1'b1;
        1: {target_vld_i, target_i} <= {1'b1, pc_i | 32'h1};
        default: {exec_i, known_i, mac_op_i, indexed_i, idx_scale_i, irq_i, opword_i}
          <= {1'b1, CTL[i], OP[i]};
      endcase
      @(posedge clk_i);
      {rd_err_i, target_vld_i, exec_i, irq_i} <= 4'h0;
      do @(posedge clk_i); while (handler_go_o !== 1'b1);
      repeat (2) @(posedge clk_i);
      wb(1'b0, 8'h04, 32'h0);
    end
    exp_q.push_back(64'h0);
    wb(1'b0, 8'h10, 32'h0);
    repeat (4) @(posedge clk_i);
    final_report();
  end
endmodule
`default_nettype wire
